/* hw/bss_top.sv */
// Stop sequencer: brake interlock, base shut-off, dynamic brake
//
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Operation
// [R1] Main power drop: decelerate, then base off
// [R2] Torque modes never use forced-stop deceleration
// [R3] Ready-off: base off, then brakes (the code drops base and brake interlock in the same cycle)
// [R4] Both powers lost: brakes at base off
// [R5] Select field zero disables deceleration
// [R6] Disabled: quick stop or immediate input brakes
// [R7] Disabled: alarm stops like dynamic brake
// [R8] Disabled: main power drop brakes at once
// [R9] Interlock on releases brake, off engages
// [R10] Lift triggers: zero speed, decel input, alarm, link
// [R11] No lift on alarms excluded from deceleration
// [R12] Lift only in position, table, homing, jog
// [R13] No lift unless compensation amount set
// [R14] No lift while deceleration disabled
// [R15] Lift by configured compensation amount
// [R16] Configurable shut-off delay in milliseconds
// [R17] Operator sets amount, then tunes delay
// [R18] Interlock off after rest, base off after delay
// [R19] Base off once speed below zero threshold
// [R20] One state machine: run, decel, delay, off
module bss_top
   import bss_pkg::*;
#(
   parameter int unsigned MS_CYC = MS_CYCLES
) (
   input  wire logic        REF_CLK_I,
   input  wire logic        RESET_N_I,
   input  wire logic        PSEL_I,
   input  wire logic        PENABLE_I,
   input  wire logic        PWRITE_I,
   input  wire logic [7:0]  PADDR_I,
   input  wire logic [31:0] PWDATA_I,
   output var  logic [31:0] PRDATA_O,
   output var  logic        PREADY_O,
   output var  logic        PSLVERR_O,
   input  wire logic        READY_ON_I,
   input  wire logic        QUICK_STOP_I,
   input  wire logic        FORCED_STOP_DECEL_INPUT_I,
   input  wire logic        FORCED_STOP_IMMEDIATE_INPUT_I,
   input  wire logic        MAIN_POWER_DROP_I,
   input  wire logic        CTRL_POWER_LOST_I,
   input  wire logic        ALARM_I,
   input  wire logic        ALARM_NODECEL_I,
   input  wire logic        COMM_LOST_I,
   input  wire logic [3:0]  OP_MODE_I,
   input  wire logic        TORQUE_ENTRY_I,
   input  wire logic [15:0] SPEED_I,
   input  wire logic        DECEL_DONE_I,
   output var  logic        BRAKE_INTERLOCK_OUTPUT_O,
   output var  logic        BASE_ON_O,
   output var  logic        DYN_BRAKE_O,
   output var  logic        DECEL_REQ_O,
   output var  logic        LIFT_REQ_O,
   output var  logic [15:0] LIFT_AMOUNT_O
);
   // ----------------------------------------------------------
   // State
   // ----------------------------------------------------------
   typedef struct packed {
      bss_state_t  st;
      logic [15:0] ms_left;
      logic [15:0] sub;
      logic        ff_arm;
      logic [3:0]  sel;
      logic [15:0] dly;
      logic [15:0] comp;
      logic [15:0] zspd;
      logic [31:0] rdata;
      logic        slverr;
   } bss_regs_t;

   localparam logic [15:0] MS_LAST = 16'(MS_CYC - 1);

   bss_regs_t q;
   bss_regs_t d;
   logic [3:0] pins_s;
   logic       em2_on;
   logic       em1_on;
   logic       main_drop;
   logic       ctrl_lost;
   logic       decel_en;
   logic       torque;
   logic       decel_ok;
   logic       ff_mode;
   logic       ff_ok;
   logic       at_zero;
   logic       soft_trig;
   logic       hard_trig;
   logic       immediate;
   logic       mapped;
   logic       setup;
   logic       wr;
   logic [7:0] stat;

   // ----------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------
   bss_sync #(
      .W (4)
   ) u_sync (
      .clk_i   (REF_CLK_I),
      .rst_n_i (RESET_N_I),
      .d_i     ({FORCED_STOP_DECEL_INPUT_I,
                 FORCED_STOP_IMMEDIATE_INPUT_I,
                 MAIN_POWER_DROP_I,
                 CTRL_POWER_LOST_I}),
      .q_o     (pins_s)
   );

   // Synchronised pin levels
   assign em2_on    = pins_s[3];
   assign em1_on    = pins_s[2];
   assign main_drop = pins_s[1];
   assign ctrl_lost = pins_s[0];

   // ----------------------------------------------------------
   // Stop qualifiers
   // ----------------------------------------------------------
   // Zero select disables deceleration (see [R5])
   assign decel_en = (q.sel != SEL_OFF);
   // Torque control never decelerates (see [R2])
   assign torque   = (OP_MODE_I == MODE_CST) ||
                     (OP_MODE_I == MODE_TQ)  ||
                     TORQUE_ENTRY_I;
   assign decel_ok = decel_en && !torque;
   // Lift allowed only in these modes (see [R12])
   assign ff_mode  = (OP_MODE_I == MODE_CSP) ||
                     (OP_MODE_I == MODE_PP)  ||
                     (OP_MODE_I == MODE_PT)  ||
                     (OP_MODE_I == MODE_HM)  ||
                     (OP_MODE_I == MODE_JG);
   // Needs amount set and deceleration on (see [R13], [R14])
   assign ff_ok    = ff_mode && decel_en && (q.comp != 16'h0000);
   assign at_zero  = (SPEED_I <= q.zspd);
   // Triggers that decelerate when enabled (see [R1])
   assign soft_trig = !em2_on || QUICK_STOP_I || ALARM_I ||
                      COMM_LOST_I || main_drop;
   // Triggers that cut the base at once, except ready-off and ALARM_NODECEL_I during the delay
   assign hard_trig = ctrl_lost || !READY_ON_I || !em1_on ||
                      ALARM_NODECEL_I;
   // Disabled deceleration turns soft triggers immediate
   assign immediate = hard_trig || (soft_trig && !decel_ok);

   // ----------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------
   assign setup  = PSEL_I && !PENABLE_I;
   assign mapped = (PADDR_I == OFS_CTRL)  ||
                   (PADDR_I == OFS_DELAY) ||
                   (PADDR_I == OFS_COMP)  ||
                   (PADDR_I == OFS_ZSPD)  ||
                   (PADDR_I == OFS_STAT);
   assign wr     = PSEL_I && PENABLE_I && PWRITE_I && !q.slverr;

   // Status word
   always_comb begin
      stat            = '0;
      stat[2:0]       = q.st;
      stat[STAT_BRK]  = BRAKE_INTERLOCK_OUTPUT_O;
      stat[STAT_BASE] = BASE_ON_O;
      stat[STAT_DB]   = DYN_BRAKE_O;
      stat[STAT_DEC]  = DECEL_REQ_O;
      stat[STAT_LIFT] = LIFT_REQ_O;
   end

   // ----------------------------------------------------------
   // Next state
   // ----------------------------------------------------------
   always_comb begin
      d = q;
      // Read data and error latched in the setup cycle
      if (setup) begin
         d.rdata  = '0;
         d.slverr = !mapped ||
                    (PWRITE_I && (PADDR_I == OFS_STAT));
         if (!PWRITE_I) begin
            unique case (PADDR_I)
               OFS_CTRL:  d.rdata = {28'h0000000, q.sel};
               OFS_DELAY: d.rdata = {16'h0000, q.dly};
               OFS_COMP:  d.rdata = {16'h0000, q.comp};
               OFS_ZSPD:  d.rdata = {16'h0000, q.zspd};
               OFS_STAT:  d.rdata = {24'h000000, stat};
               default:   d.rdata = '0;
            endcase
         end
      end
      // Register writes in the access cycle
      if (wr) begin
         unique case (PADDR_I)
            OFS_CTRL:  d.sel  = PWDATA_I[SEL_W-1:0];
            OFS_DELAY: d.dly  = PWDATA_I[15:0];  // see [R16]
            OFS_COMP:  d.comp = PWDATA_I[15:0];  // see [R15]
            OFS_ZSPD:  d.zspd = PWDATA_I[15:0];
            default:   d.sel  = q.sel;
         endcase
      end
      // Stop sequence (see [R20])
      unique case (q.st)
         ST_OFF: begin
            d.ff_arm = 1'b0;
            if (READY_ON_I && !hard_trig && !soft_trig) begin
               d.st = ST_RUN;
            end
         end
         ST_RUN: begin
            if (immediate) begin
               // Base off with brakes (see [R3], [R4], [R6])
               // Alarm or drop when disabled (see [R7], [R8])
               d.st = ST_OFF;
            end else if (soft_trig) begin
               // Decelerate first (see [R1], [R2])
               d.st     = ST_DECEL;
               // Lift triggers, excluded alarms never (see [R10], [R11])
               d.ff_arm = at_zero || !em2_on || ALARM_I ||
                          COMM_LOST_I;
            end
         end
         ST_DECEL: begin
            if (hard_trig) begin
               d.st = ST_OFF;  // see [R4]
            end else if (DECEL_DONE_I && at_zero) begin
               // At rest: interlock off (see [R18], [R19])
               d.ms_left = q.dly;
               d.sub     = MS_LAST;
               d.st      = (q.dly == 16'h0000) ? ST_OFF : ST_BRK_DLY;
            end
         end
         ST_BRK_DLY: begin
            if (ctrl_lost || !em1_on) begin
               d.st = ST_OFF;
            end else if (q.sub == 16'h0000) begin
               // One millisecond elapsed (see [R16], [R18])
               d.sub     = MS_LAST;
               d.ms_left = q.ms_left - 16'h0001;
               if (q.ms_left == 16'h0001) begin
                  d.st = ST_OFF;
               end
            end else begin
               d.sub = q.sub - 16'h0001;
            end
         end
         default: begin
            d.st = ST_OFF;
         end
      endcase
   end

   // ----------------------------------------------------------
   // State register
   // ----------------------------------------------------------
   always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         q.st      <= ST_OFF;
         q.ms_left <= '0;
         q.sub     <= '0;
         q.ff_arm  <= 1'b0;
         q.sel     <= SEL_RST;
         q.dly     <= DELAY_RST;
         q.comp    <= COMP_RST;
         q.zspd    <= ZSPD_RST;
         q.rdata   <= '0;
         q.slverr  <= 1'b0;
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------
   // Interlock on holds the brake released (see [R9])
   assign BRAKE_INTERLOCK_OUTPUT_O = (q.st == ST_RUN) ||
                                     (q.st == ST_DECEL);
   assign BASE_ON_O     = (q.st != ST_OFF);
   assign DYN_BRAKE_O   = (q.st == ST_OFF);
   assign DECEL_REQ_O   = (q.st == ST_DECEL);
   // Lift during the shut-off delay (see [R10], [R15])
   assign LIFT_REQ_O    = (q.st == ST_BRK_DLY) && q.ff_arm && ff_ok;
   assign LIFT_AMOUNT_O = q.comp;
   assign PRDATA_O      = q.rdata;
   assign PREADY_O      = 1'b1;
   assign PSLVERR_O     = q.slverr && PSEL_I && PENABLE_I;

   // ----------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------
   default clocking cb @(posedge REF_CLK_I);
   endclocking
   default disable iff (!RESET_N_I);

   sequence run_s;
      q.st == ST_RUN;
   endsequence

   sequence halted_s;
      !BASE_ON_O && DYN_BRAKE_O && !BRAKE_INTERLOCK_OUTPUT_O;
   endsequence

   ready_off_a: assert property ( // see [R3]
      run_s and (!READY_ON_I) |=> halted_s
   ) else $error("Ready-off did not halt");

   power_loss_a: assert property ( // see [R4]
      ctrl_lost |=> !BASE_ON_O
   ) else $error("Base stayed on after power loss");

   torque_decel_a: assert property ( // see [R2]
      torque && (q.st != ST_DECEL) |=> !DECEL_REQ_O
   ) else $error("Deceleration in torque mode");

   sel_off_a: assert property ( // see [R5]
      (q.sel == SEL_OFF) && (q.st != ST_DECEL) |=> !DECEL_REQ_O
   ) else $error("Deceleration while disabled");

   em1_stop_a: assert property ( // see [R6]
      run_s and (!em1_on) |=> halted_s
   ) else $error("Immediate stop not taken");

   alarm_stop_a: assert property ( // see [R7]
      run_s and (ALARM_I && !decel_ok) |=> halted_s
   ) else $error("Alarm stop decelerated");

   drop_decel_a: assert property ( // see [R1]
      run_s and (main_drop && decel_ok && !hard_trig)
      |=> DECEL_REQ_O && BASE_ON_O
   ) else $error("Power drop did not decelerate");

   drop_nodec_a: assert property ( // see [R8]
      run_s and (main_drop && !decel_en) |=> halted_s
   ) else $error("Power drop not braked");

   brake_base_a: assert property ( // see [R9]
      !BASE_ON_O |-> !BRAKE_INTERLOCK_OUTPUT_O
   ) else $error("Brake released with base off");

   lift_gate_a: assert property ( // see [R12]
      LIFT_REQ_O |-> ff_mode && (q.comp != 16'h0000) && decel_en
   ) else $error("Lift outside its conditions");

   decel_rest_a: assert property ( // see [R18]
      DECEL_REQ_O && !hard_trig && DECEL_DONE_I && at_zero
      && (q.dly != 16'h0000)
      |=> !BRAKE_INTERLOCK_OUTPUT_O && BASE_ON_O
   ) else $error("Interlock not dropped at rest");

   zero_dly_a: assert property ( // see [R19]
      DECEL_REQ_O && !hard_trig && DECEL_DONE_I && at_zero
      && (q.dly == 16'h0000) |=> halted_s
   ) else $error("Base not cut at zero speed");
endmodule
`default_nettype wire

/* hw/bss_pkg.sv */
// Constants and types shared by the brake stop sequencer
`default_nettype none
package bss_pkg;
   // ----------------------------------------------------------
   // Timing
   // ----------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 25;
   localparam int unsigned MS_NS         = 1000000;
   localparam int unsigned MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
   // ----------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------
   localparam logic [7:0] OFS_CTRL  = 8'h00;
   localparam logic [7:0] OFS_DELAY = 8'h04;
   localparam logic [7:0] OFS_COMP  = 8'h08;
   localparam logic [7:0] OFS_ZSPD  = 8'h0C;
   localparam logic [7:0] OFS_STAT  = 8'h10;
   // ----------------------------------------------------------
   // Fields and reset values
   // ----------------------------------------------------------
   localparam int unsigned SEL_W     = 4;
   localparam logic [3:0]  SEL_OFF   = 4'h0;
   localparam logic [3:0]  SEL_RST   = 4'h0;
   localparam logic [15:0] DELAY_RST = 16'h0000;
   localparam logic [15:0] COMP_RST  = 16'h0000;
   localparam logic [15:0] ZSPD_RST  = 16'h0032;
   localparam int unsigned STAT_BRK  = 3;
   localparam int unsigned STAT_BASE = 4;
   localparam int unsigned STAT_DB   = 5;
   localparam int unsigned STAT_DEC  = 6;
   localparam int unsigned STAT_LIFT = 7;
   // ----------------------------------------------------------
   // Stop sequence states and operating modes
   // ----------------------------------------------------------
   typedef enum logic [2:0] {
      ST_OFF     = 3'b000,
      ST_RUN     = 3'b001,
      ST_DECEL   = 3'b010,
      ST_BRK_DLY = 3'b011
   } bss_state_t;
   typedef enum logic [3:0] {
      MODE_CSP = 4'h0,
      MODE_CSV = 4'h1,
      MODE_CST = 4'h2,
      MODE_PP  = 4'h3,
      MODE_PV  = 4'h4,
      MODE_TQ  = 4'h5,
      MODE_HM  = 4'h6,
      MODE_PT  = 4'h7,
      MODE_JG  = 4'h8
   } bss_mode_t;
endpackage
`default_nettype wire

/* hw/bss_sync.sv */
// Two-stage synchroniser for asynchronous pin levels
`timescale 1ns/1ps
`default_nettype none
module bss_sync #(
   parameter int unsigned W = 1
) (
   input  wire logic         clk_i,
   input  wire logic         rst_n_i,
   input  wire logic [W-1:0] d_i,
   output var  logic [W-1:0] q_o
);
   logic [W-1:0] meta_q;
   // ----------------------------------------------------------
   // Synchroniser chain
   // ----------------------------------------------------------
   // First stage feeds only the second stage
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_q <= '0;
         q_o    <= '0;
      end else begin
         meta_q <= d_i;
         q_o    <= meta_q;
      end
   end
endmodule
`default_nettype wire

/* dv/bss_motor_model.sv */
// Motor and deceleration profile stand-in facing the stop sequencer
`timescale 1ns/1ps
`default_nettype none
module bss_motor_model (
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        base_on_i,
   input  wire logic        decel_req_i,
   input  wire logic        slow_i,
   output var  logic [15:0] speed_o,
   output var  logic        decel_done_o
);
   logic [15:0] step;
   // Speed lost per cycle while ramping down
   assign step = slow_i ? 16'h0010 : 16'h0040;
   // Spin while powered, ramp to rest under deceleration
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         speed_o <= 16'h0000;
      end else if (!base_on_i) begin
         speed_o <= 16'h0000;
      end else if (!decel_req_i) begin
         speed_o <= 16'h0200;
      end else begin
         speed_o <= (speed_o > step) ? speed_o - step : 16'h0000;
      end
   end
   // Ramp command finished once the shaft is at rest
   assign decel_done_o = decel_req_i && (speed_o == 16'h0000);
endmodule
`default_nettype wire

/* dv/bss_top_tb_top.sv */
// Self-checking bench for the brake stop sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin miscompares++; \
   $display("wrong value at %0t: got %h exp %h", $time, a, b); end end
module bss_top_tb_top
   import bss_pkg::*;
;
   localparam int MS = 4;
   // Bit t set: trigger t decelerates (ED) or lifts (EL) with deceleration on
   localparam logic [8:0] ED = 9'h156;
   localparam logic [8:0] EL = 9'h144;
   logic        clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, d;
   logic        pready, pslverr, e, rdy = 0, qs = 0, em2 = 1, em1 = 1;
   logic        mdrop = 0, plost = 0, alm = 0, alnd = 0, comm = 0, tent = 0, slow = 0;
   logic [3:0]  mode = MODE_CSP;
   logic [15:0] speed, lamt;
   logic        done, brk, base, dbrk, dreq, lreq;
   int          miscompares = 0, checked = 0, cyc = 0;
   // -----------------------------------------------------------
   // Clock, design and far side
   // -----------------------------------------------------------
   always #12.5 clk = ~clk;
   bss_top #(.MS_CYC(MS)) i_dut (.REF_CLK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel),
      .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
      .PREADY_O(pready), .PSLVERR_O(pslverr), .READY_ON_I(rdy), .QUICK_STOP_I(qs),
      .FORCED_STOP_DECEL_INPUT_I(em2), .FORCED_STOP_IMMEDIATE_INPUT_I(em1),
      .MAIN_POWER_DROP_I(mdrop), .CTRL_POWER_LOST_I(plost), .ALARM_I(alm),
      .ALARM_NODECEL_I(alnd), .COMM_LOST_I(comm), .OP_MODE_I(mode), .TORQUE_ENTRY_I(tent),
      .SPEED_I(speed), .DECEL_DONE_I(done), .BRAKE_INTERLOCK_OUTPUT_O(brk), .BASE_ON_O(base),
      .DYN_BRAKE_O(dbrk), .DECEL_REQ_O(dreq), .LIFT_REQ_O(lreq), .LIFT_AMOUNT_O(lamt));
   bss_motor_model i_motor (.clk_i(clk), .rst_n_i(rst_n), .base_on_i(base),
      .decel_req_i(dreq), .slow_i(slow), .speed_o(speed), .decel_done_o(done));
   // -----------------------------------------------------------
   // Tasks
   // -----------------------------------------------------------
   // Verdict and end of run
   task results();
      $display("checks %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // One APB transfer, request held until pready is sampled high
   task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk);
      psel   <= 1'b1;
      pen    <= 1'b0;
      pwr    <= w;
      paddr  <= a;
      pwdata <= wd;
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      d = prdata;
      e = pslverr;
      psel <= 1'b0;
      pen  <= 1'b0;
   endtask
   // All stop inputs good, wait for the axis to run
   task go();
      int n;
      @(posedge clk);
      rdy <= 1; qs <= 0; em2 <= 1; em1 <= 1; mdrop <= 0; plost <= 0;
      alm <= 0; alnd <= 0; comm <= 0;
      for (n = 0; n < 100 && base !== 1'b1; n++) @(negedge clk);
      `CHK(brk, 1'b1)
   endtask
   // Fire one stop trigger and watch the shutdown order
   task stop(input int t, input logic ed, input logic el, input int gap);
      int n, ti, tb;
      logic sd, sl;
      go();
      @(posedge clk);
      case (t)
         0: rdy <= 0;
         1: qs <= 1;
         2: em2 <= 0;
         3: em1 <= 0;
         4: mdrop <= 1;
         5: plost <= 1;
         6: alm <= 1;
         7: alnd <= 1;
         default: comm <= 1;
      endcase
      sd = 0; sl = 0; ti = -1; tb = -1;
      for (n = 0; n < 300 && tb < 0; n++) begin
         @(negedge clk);
         sd |= dreq;
         sl |= lreq;
         if (ti < 0 && brk === 1'b0) ti = n;
         if (base === 1'b0) tb = n;
      end
      if (sl) `CHK(lamt, 16'h0005)
      `CHK(sd, ed)
      `CHK(sl, el)
      `CHK(tb - ti, gap)
      `CHK(dbrk, 1'b1)
      $display("stop test trigger %0d mode %0d ended", t, mode);
   endtask
   // Change operating mode on a rising edge between stop tests
   task set_mode(input logic [3:0] m, input logic te, input logic sw);
      @(posedge clk);
      mode <= m;
      tent <= te;
      slow <= sw;
   endtask
   // Hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         miscompares++;
         results();
      end
   end
   // -----------------------------------------------------------
   // Test sequence
   // -----------------------------------------------------------
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      bus(1'b0, OFS_CTRL, 32'h00000000);
      `CHK(d, {28'h0000000, SEL_RST})
      bus(1'b0, OFS_DELAY, 32'h00000000);
      `CHK(d, {16'h0000, DELAY_RST})
      bus(1'b0, OFS_COMP, 32'h00000000);
      `CHK(d, {16'h0000, COMP_RST})
      bus(1'b0, OFS_ZSPD, 32'h00000000);
      `CHK(d, {16'h0000, ZSPD_RST})
      bus(1'b0, OFS_STAT, 32'h00000000);
      `CHK(d, 32'h00000001 << STAT_DB)
      bus(1'b0, 8'h14, 32'h00000000);
      `CHK(e, 1'b1)
      bus(1'b1, OFS_STAT, 32'h000000FF);
      `CHK(e, 1'b1)
      $display("register test ended");
      for (int t = 0; t < 9; t++) stop(t, 1'b0, 1'b0, 0);
      bus(1'b1, OFS_CTRL, 32'h00000002);
      bus(1'b1, OFS_COMP, 32'h00000005);
      bus(1'b1, OFS_DELAY, 32'h00000002);
      bus(1'b0, OFS_COMP, 32'h00000000);
      `CHK(d, 32'h00000005)
      for (int t = 0; t < 9; t++) stop(t, ED[t], EL[t], ED[t] ? 2 * MS : 0);
      set_mode(MODE_CST, 1'b0, 1'b0);
      stop(2, 1'b0, 1'b0, 0);
      set_mode(MODE_TQ, 1'b0, 1'b0);
      stop(1, 1'b0, 1'b0, 0);
      set_mode(MODE_CSP, 1'b1, 1'b0);
      stop(2, 1'b0, 1'b0, 0);
      set_mode(MODE_CSV, 1'b0, 1'b0);
      stop(2, 1'b1, 1'b0, 2 * MS);
      set_mode(MODE_HM, 1'b0, 1'b0);
      stop(2, 1'b1, 1'b1, 2 * MS);
      set_mode(MODE_PT, 1'b0, 1'b0);
      stop(6, 1'b1, 1'b1, 2 * MS);
      set_mode(MODE_JG, 1'b0, 1'b1);
      stop(8, 1'b1, 1'b1, 2 * MS);
      set_mode(MODE_CSP, 1'b0, 1'b0);
      // Threshold equal to running speed: quick stop arms the lift
      bus(1'b1, OFS_ZSPD, 32'h00000200);
      bus(1'b0, OFS_ZSPD, 32'h00000000);
      `CHK(d, 32'h00000200)
      stop(1, 1'b1, 1'b1, 2 * MS);
      bus(1'b1, OFS_ZSPD, {16'h0000, ZSPD_RST});
      // Zero delay: base cut at rest together with the interlock
      bus(1'b1, OFS_DELAY, 32'h00000000);
      stop(1, 1'b1, 1'b0, 0);
      // Deceleration off with amount set: no lift
      bus(1'b1, OFS_CTRL, 32'h00000000);
      stop(2, 1'b0, 1'b0, 0);
      bus(1'b1, OFS_CTRL, 32'h00000002);
      bus(1'b1, OFS_DELAY, 32'h00000002);
      bus(1'b1, OFS_COMP, 32'h00000000);
      stop(2, 1'b1, 1'b0, 2 * MS);
      results();
   end
endmodule
`default_nettype wire
